/* File: shared/fmu_map.svh */
// Offsets, fields, reset values and timing counts of the fp move/multiply unit
`ifndef FMU_MAP_SVH
`define FMU_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define FMU_STATUS_OFF 12'h000
`define FMU_MASK_OFF 12'h004
`define FMU_CTRL_OFF 12'h008
`define FMU_RETIRED_OFF 12'h00C

// ==========================================================================
// Field positions
`define FMU_EV_ADDR_ERR 0
`define FMU_EV_INVALID 1
`define FMU_EV_W 2
`define FMU_CTRL_ENABLE 0

// ==========================================================================
// Reset values
`define FMU_STATUS_RST 2'h0
`define FMU_MASK_RST 2'h0
`define FMU_ENABLE_RST 1'h1

// ==========================================================================
// Opcode fields
`define FMU_OPC_PREFIX 4'hF
`define FMU_OPC_MOVE 4'hC
`define FMU_OPC_LOAD 4'h8
`define FMU_OPC_STORE 4'hA
`define FMU_OPC_LOAD_INC 4'h9
`define FMU_OPC_STORE_DEC 4'hB
`define FMU_OPC_LOAD_IDX 4'h6
`define FMU_OPC_STORE_IDX 4'h7
`define FMU_OPC_MUL 4'h2

// ==========================================================================
// Arithmetic and timing constants
`define FMU_PC_STEP 32'h00000002
`define FMU_ADDR_STEP 32'h00000004
`define FMU_QNAN 32'h7FBFFFFF
`define FMU_EXP_BIAS 10'h07F
`define FMU_EXP_MAX 10'h0FF
`define FMU_LATENCY 2

`endif

/* File: shared/fmu_pkg.sv */
// Types of the fp move/multiply unit
package fmu_pkg;

  // ========================================================================
  // Execution stage state, Gray coded
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b11
  } fmu_state_t;

  // ========================================================================
  // Decoded operation
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_REG_MOVE = 4'h1,
    OP_LOAD = 4'h2,
    OP_STORE = 4'h3,
    OP_LOAD_INC = 4'h4,
    OP_STORE_DEC = 4'h5,
    OP_LOAD_IDX = 4'h6,
    OP_STORE_IDX = 4'h7,
    OP_MULTIPLY = 4'h8
  } fmu_op_t;

  // ========================================================================
  // Whole state of the top module
  typedef struct packed {
    fmu_state_t state;
    fmu_op_t op;
    logic [3:0] n;
    logic [3:0] m;
    logic [31:0] fsrc;
    logic [31:0] fdst;
    logic [31:0] addr;
    logic misaligned;
    logic [31:0] pc;
    logic wb_valid;
    logic fp_wr_en;
    logic [3:0] fp_wr_idx;
    logic [31:0] fp_wr_data;
    logic gp_wr_en;
    logic [3:0] gp_wr_idx;
    logic [31:0] gp_wr_data;
    logic [31:0] pc_next;
    logic addr_error;
    logic invalid_op;
    logic [1:0] status;
    logic [1:0] mask;
    logic enable;
    logic [31:0] retired;
    logic [31:0] prdata;
    logic pslverr;
  } fmu_regs_t;

endpackage

/* File: shared/fmu_mul_if.sv */
// Operand and result bundle between the unit and its multiplier
`timescale 1ns/1ns
interface fmu_mul_if;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [31:0] product;
  logic invalid;

  modport requester (output op_a, output op_b, input product, input invalid);
  modport multiplier (input op_a, input op_b, output product, output invalid);
endinterface

/* File: src/fmu_mul.sv */
// Single-precision multiplier with special-case handling
`timescale 1ns/1ns
`include "fmu_map.svh"
module fmu_mul (
  // Operands and result
  fmu_mul_if.multiplier mul
);
  import fmu_pkg::*;

  // ========================================================================
  // Operand classification
  function automatic logic [31:0] flush(input logic [31:0] x);
    flush = (x[30:23] == 8'h00) ? {x[31], 31'h0} : x;
  endfunction

  function automatic logic is_nan(input logic [31:0] x);
    is_nan = (x[30:23] == 8'hFF) && (x[22:0] != 23'h0);
  endfunction

  function automatic logic is_snan(input logic [31:0] x);
    // Fraction top bit set marks signaling, so the written quiet NaN is quiet
    is_snan = is_nan(x) && x[22];
  endfunction

  function automatic logic is_inf(input logic [31:0] x);
    is_inf = (x[30:23] == 8'hFF) && (x[22:0] == 23'h0);
  endfunction

  function automatic logic is_zero(input logic [31:0] x);
    is_zero = (x[30:0] == 31'h0);
  endfunction

  // ========================================================================
  // Special cases first, then the truncated product
  always_comb begin
    logic [31:0] a;
    logic [31:0] b;
    logic sgn;
    logic [47:0] prod;
    logic [9:0] exp;
    logic [22:0] mant;
    a = flush(mul.op_a);
    b = flush(mul.op_b);
    sgn = a[31] ^ b[31];
    prod = {1'b1, a[22:0]} * {1'b1, b[22:0]};
    exp = {2'b00, a[30:23]} + {2'b00, b[30:23]} - `FMU_EXP_BIAS
          + {9'h000, prod[47]};
    mant = prod[47] ? prod[46:24] : prod[45:23];
    mul.invalid = 1'b0;
    if (is_snan(a) || is_snan(b)) begin
      mul.product = `FMU_QNAN;
      mul.invalid = 1'b1;
    end else if (is_nan(a) || is_nan(b)) begin
      mul.product = `FMU_QNAN;
    end else if ((is_zero(a) && is_inf(b)) || (is_inf(a) && is_zero(b))) begin
      mul.product = `FMU_QNAN;
      mul.invalid = 1'b1;
    end else if (is_inf(a) || is_inf(b)) begin
      mul.product = {sgn, 8'hFF, 23'h0};
    end else if (is_zero(a) || is_zero(b)) begin
      mul.product = {sgn, 31'h0};
    end else if (exp[9] || exp == 10'h000) begin
      mul.product = {sgn, 31'h0};
    end else if (exp >= `FMU_EXP_MAX) begin
      mul.product = {sgn, 8'hFF, 23'h0};
    end else begin
      mul.product = {sgn, exp[7:0], mant};
    end
  end

  // ========================================================================
  // Checks
  always_comb begin
    snan_invalid_a: assert final (
        !(is_snan(mul.op_a) && !mul.invalid))
      else $error("signaling NaN operand without invalid");
    qnan_quiet_a: assert final (!(is_nan(mul.op_a)
        && !is_snan(mul.op_a) && !is_snan(mul.op_b) && (mul.invalid
        || mul.product != `FMU_QNAN)))
      else $error("quiet NaN operand gave wrong result");
  end
endmodule // fmu_mul

/* File: src/fmu_unit.sv */
// Execution unit for single-precision move and multiply instructions
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "fmu_map.svh"
module fmu_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Instruction issue with operand values
  input wire logic issue_valid,
  output logic issue_ready,
  input wire logic [15:0] issue_opcode,
  input wire logic [31:0] issue_pc,
  input wire logic [31:0] fp_src_data,
  input wire logic [31:0] fp_dst_data,
  input wire logic [31:0] gp_src_data,
  input wire logic [31:0] gp_dst_data,
  input wire logic [31:0] index_data,
  // Data memory port
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic mem_err,
  // Writeback
  output logic wb_valid,
  output logic fp_wr_en,
  output logic [3:0] fp_wr_idx,
  output logic [31:0] fp_wr_data,
  output logic gp_wr_en,
  output logic [3:0] gp_wr_idx,
  output logic [31:0] gp_wr_data,
  output logic [31:0] pc_next,
  output logic addr_error,
  output logic invalid_op
);
  import fmu_pkg::*;

  fmu_regs_t r;
  fmu_regs_t next_r;
  fmu_mul_if mul_bus ();

  // ========================================================================
  // Decode
  function automatic fmu_op_t decode(input logic [15:0] opc);
    decode = OP_NONE;
    if (opc[15:12] == `FMU_OPC_PREFIX) begin
      unique case (opc[3:0])
        `FMU_OPC_MOVE: decode = OP_REG_MOVE;
        `FMU_OPC_LOAD: decode = OP_LOAD;
        `FMU_OPC_STORE: decode = OP_STORE;
        `FMU_OPC_LOAD_INC: decode = OP_LOAD_INC;
        `FMU_OPC_STORE_DEC: decode = OP_STORE_DEC;
        `FMU_OPC_LOAD_IDX: decode = OP_LOAD_IDX;
        `FMU_OPC_STORE_IDX: decode = OP_STORE_IDX;
        `FMU_OPC_MUL: decode = OP_MULTIPLY;
        default: decode = OP_NONE;
      endcase
    end
  endfunction

  function automatic logic is_mem(input fmu_op_t op);
    is_mem = (op != OP_NONE) && (op != OP_REG_MOVE) && (op != OP_MULTIPLY);
  endfunction

  function automatic logic is_store(input fmu_op_t op);
    is_store = (op == OP_STORE) || (op == OP_STORE_DEC)
               || (op == OP_STORE_IDX);
  endfunction

  // ========================================================================
  // Handshakes and memory port
  logic busy;
  logic done;
  logic fault;
  fmu_op_t issue_op;
  logic apb_setup;
  logic [`FMU_EV_W-1:0] events;

  assign busy = (r.state != ST_IDLE);
  assign issue_op = decode(issue_opcode);
  assign done = busy && (!is_mem(r.op) || r.misaligned || mem_ack);
  assign fault = r.misaligned || (mem_ack && mem_err);
  assign issue_ready = r.enable && (!busy || done);
  assign mem_req = busy && is_mem(r.op) && !r.misaligned;
  assign mem_we = is_store(r.op);
  assign mem_addr = r.addr;
  assign mem_wdata = r.fsrc;
  assign apb_setup = psel && !penable;
  assign mul_bus.op_a = r.fdst;
  assign mul_bus.op_b = r.fsrc;

  fmu_mul u_mul (
    .mul(mul_bus.multiplier)
  );

  // ========================================================================
  // Next state
  always_comb begin
    next_r = r;
    events = '0;
    next_r.wb_valid = 1'b0;
    next_r.fp_wr_en = 1'b0;
    next_r.gp_wr_en = 1'b0;
    next_r.addr_error = 1'b0;
    next_r.invalid_op = 1'b0;

    // Retire the instruction in the execution stage
    if (done) begin
      next_r.state = ST_IDLE;
      next_r.wb_valid = 1'b1;
      next_r.pc_next = r.pc + `FMU_PC_STEP;
      next_r.retired = r.retired + 32'h00000001;
      next_r.fp_wr_idx = r.n;
      next_r.addr_error = is_mem(r.op) && fault;
      unique case (r.op)
        OP_REG_MOVE: begin
          next_r.fp_wr_en = 1'b1;
          next_r.fp_wr_data = r.fsrc;
        end
        OP_MULTIPLY: begin
          next_r.fp_wr_en = 1'b1;
          next_r.fp_wr_data = mul_bus.product;
          next_r.invalid_op = mul_bus.invalid;
        end
        OP_LOAD, OP_LOAD_IDX: begin
          next_r.fp_wr_en = !fault;
          next_r.fp_wr_data = mem_rdata;
        end
        OP_LOAD_INC: begin
          next_r.fp_wr_en = !fault;
          next_r.fp_wr_data = mem_rdata;
          next_r.gp_wr_en = !fault;
          next_r.gp_wr_idx = r.m;
          next_r.gp_wr_data = r.addr + `FMU_ADDR_STEP;
        end
        OP_STORE_DEC: begin
          next_r.gp_wr_en = !fault;
          next_r.gp_wr_idx = r.n;
          next_r.gp_wr_data = r.addr;
        end
        OP_STORE, OP_STORE_IDX: begin
          next_r.gp_wr_en = 1'b0;
        end
        default: begin
          next_r.wb_valid = 1'b0;
        end
      endcase
      events[`FMU_EV_ADDR_ERR] = next_r.addr_error;
      events[`FMU_EV_INVALID] = next_r.invalid_op;
    end else if (busy) begin
      next_r.state = ST_WAIT;
    end

    // Accept a new instruction into the execution stage
    if (issue_valid && issue_ready && issue_op != OP_NONE) begin
      next_r.state = ST_EXEC;
      next_r.op = issue_op;
      next_r.n = issue_opcode[11:8];
      next_r.m = issue_opcode[7:4];
      next_r.fsrc = fp_src_data;
      next_r.fdst = fp_dst_data;
      next_r.pc = issue_pc;
      unique case (issue_op)
        OP_STORE_DEC: next_r.addr = gp_dst_data - `FMU_ADDR_STEP;
        OP_LOAD_IDX: next_r.addr = index_data + gp_src_data;
        OP_STORE_IDX: next_r.addr = index_data + gp_dst_data;
        OP_STORE: next_r.addr = gp_dst_data;
        default: next_r.addr = gp_src_data;
      endcase
      next_r.misaligned = (next_r.addr[1:0] != 2'b00);
    end

    // APB registers; a new event wins over a write-one clear
    next_r.status = r.status | events;
    if (psel && penable && pwrite) begin
      unique case (paddr)
        `FMU_STATUS_OFF:
          next_r.status = (r.status & ~pwdata[`FMU_EV_W-1:0]) | events;
        `FMU_MASK_OFF: next_r.mask = pwdata[`FMU_EV_W-1:0];
        `FMU_CTRL_OFF: next_r.enable = pwdata[`FMU_CTRL_ENABLE];
        default: next_r.mask = r.mask;
      endcase
    end
    if (apb_setup) begin
      next_r.pslverr = 1'b0;
      unique case (paddr)
        `FMU_STATUS_OFF: next_r.prdata = {30'h0, r.status};
        `FMU_MASK_OFF: next_r.prdata = {30'h0, r.mask};
        `FMU_CTRL_OFF: next_r.prdata = {31'h0, r.enable};
        `FMU_RETIRED_OFF: next_r.prdata = r.retired;
        default: begin
          next_r.prdata = 32'h00000000;
          next_r.pslverr = 1'b1;
        end
      endcase
    end
  end

  // ========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.state <= ST_IDLE;
      r.op <= OP_NONE;
      r.status <= `FMU_STATUS_RST;
      r.mask <= `FMU_MASK_RST;
      r.enable <= `FMU_ENABLE_RST;
    end else begin
      r <= next_r;
    end
  end

  // ========================================================================
  // Outputs
  assign prdata = r.prdata;
  assign pready = 1'b1;
  assign pslverr = r.pslverr && psel && penable;
  assign irq = |(r.status & r.mask);
  assign wb_valid = r.wb_valid;
  assign fp_wr_en = r.fp_wr_en;
  assign fp_wr_idx = r.fp_wr_idx;
  assign fp_wr_data = r.fp_wr_data;
  assign gp_wr_en = r.gp_wr_en;
  assign gp_wr_idx = r.gp_wr_idx;
  assign gp_wr_data = r.gp_wr_data;
  assign pc_next = r.pc_next;
  assign addr_error = r.addr_error;
  assign invalid_op = r.invalid_op;

  // ========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence mul_issue_s;
    issue_valid && issue_ready && decode(issue_opcode) == OP_MULTIPLY;
  endsequence

  sequence wb_fp_s;
    !wb_valid ##1 wb_valid && fp_wr_en;
  endsequence

  sequence move_issue_s;
    issue_valid && issue_ready && decode(issue_opcode) == OP_REG_MOVE;
  endsequence

  mul_latency_a: assert property (mul_issue_s |=> wb_fp_s)
    else $error("multiply result not after two cycles");

  move_copy_a: assert property (move_issue_s
      |-> ##2 (fp_wr_en && fp_wr_data == $past(fp_src_data, 2)))
    else $error("register move did not copy source bits");

  pc_step_a: assert property (wb_valid |->
      pc_next == $past(r.pc) + `FMU_PC_STEP)
    else $error("pc did not advance by two");

  fault_nowrite_a: assert property (addr_error |->
      !fp_wr_en && !gp_wr_en)
    else $error("registers written on address error");

  misalign_noreq_a: assert property (busy && r.misaligned
      |-> !mem_req)
    else $error("memory request on misaligned address");

  postinc_wb_a: assert property (done && r.op == OP_LOAD_INC
      && !fault |=> gp_wr_en && gp_wr_data == $past(r.addr) + 32'h4)
    else $error("post-increment writeback wrong");

  predec_addr_a: assert property (issue_valid && issue_ready
      && decode(issue_opcode) == OP_STORE_DEC
      |=> mem_addr == $past(gp_dst_data) - 32'h4 && mem_we)
    else $error("pre-decrement address wrong");

  index_addr_a: assert property (issue_valid && issue_ready
      && decode(issue_opcode) == OP_LOAD_IDX
      |=> mem_addr == $past(index_data) + $past(gp_src_data) && !mem_we)
    else $error("indexed load address wrong");

  index_store_a: assert property (done && r.op == OP_STORE_IDX
      |=> !gp_wr_en && !fp_wr_en)
    else $error("indexed store changed a register");

  store_data_a: assert property (issue_valid && issue_ready
      && is_store(decode(issue_opcode))
      |=> mem_wdata == $past(fp_src_data))
    else $error("store data is not the fp source");

  load_data_a: assert property (done && r.op == OP_LOAD
      && !fault |=> fp_wr_en && fp_wr_data == $past(mem_rdata))
    else $error("load data not written");

  mul_invalid_a: assert property (done && r.op == OP_MULTIPLY
      |=> invalid_op == $past(mul_bus.invalid))
    else $error("invalid flag lost");

  status_sticky_a: assert property (invalid_op |=>
      r.status[`FMU_EV_INVALID])
    else $error("invalid event not recorded");
endmodule // fmu_unit

/* File: bench/fmu_mem_model.sv */
// Data memory slave model for the fp move/multiply unit
`timescale 1ns/1ns
module fmu_mem_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [1:0] slow,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  output logic mem_err
);
  logic [31:0] mem [0:63];
  logic [1:0] cnt;

  // Upper half of the address space faults; read data toggles when not acking, mem_err only when no request awaits an ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= 32'h0;
      cnt <= 2'h0;
    end else if (mem_req && !mem_ack && cnt < slow) begin
      cnt <= cnt + 2'h1;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && !mem_ack) begin
      cnt <= 2'h0;
      mem_ack <= 1'b1;
      mem_err <= mem_addr[31];
      mem_rdata <= mem[mem_addr[7:2]];
      if (mem_we && !mem_addr[31])
        mem[mem_addr[7:2]] <= mem_wdata;
    end else begin
      mem_ack <= 1'b0;
      mem_err <= ~mem_err;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // fmu_mem_model

/* File: bench/tb.sv */
// Self-checking bench of the fp move/multiply unit
`timescale 1ns/1ns
`include "fmu_map.svh"
module tb;
  import fmu_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, issue_pc = 0, mem_rdata, mem_addr;
  logic pready, pslverr, irq, issue_valid = 0, issue_ready, mem_req, mem_we;
  logic [15:0] issue_opcode = 0;
  logic [31:0] fp_src_data = 0, fp_dst_data = 0, gp_src_data = 0;
  logic [31:0] gp_dst_data = 0, index_data = 0, mem_wdata, pc_next;
  logic mem_ack, mem_err, wb_valid, fp_wr_en, gp_wr_en, addr_error;
  logic invalid_op, saw_req = 0;
  logic [3:0] fp_wr_idx, gp_wr_idx, n, m;
  logic [31:0] fp_wr_data, gp_wr_data, pc, c_fd, c_gd, c_pc;
  logic [1:0] slow = 0;
  logic c_fe, c_ge, c_ae, c_io;
  logic [3:0] c_fi, c_gi;
  int err_count = 0, cmp_count = 0, ret = 0, lat, cyc = 0;
  logic [63:0] mcase [8] = '{64'h40000000_40800000, 64'h7FC00000_3F800000,
    64'h7F800001_7FC00000, 64'h7F800001_3F800000, 64'h00000001_FF800000,
    64'h80400000_C0000000, 64'h7F800000_C0000000, 64'h80000000_40400000};

  fmu_unit u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .issue_valid, .issue_ready,
    .issue_opcode, .issue_pc, .fp_src_data, .fp_dst_data, .gp_src_data,
    .gp_dst_data, .index_data, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack, .mem_err, .wb_valid, .fp_wr_en, .fp_wr_idx,
    .fp_wr_data, .gp_wr_en, .gp_wr_idx, .gp_wr_data, .pc_next,
    .addr_error, .invalid_op);
  fmu_mem_model u_mem (.pclk, .presetn, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .slow, .mem_rdata, .mem_ack, .mem_err);

  initial begin
    forever #5 pclk = ~pclk;
  end

  // ========================================================================
  // Reporting
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  always @(posedge pclk) begin
    if (mem_req === 1'b1)
      saw_req <= 1'b1;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("unexpected at %0t: run hung", $time);
      complete_run();
    end
  end

  // ========================================================================
  // Bus and issue drivers, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic irq_is(input logic v);
    repeat (2) @(negedge pclk);
    chk(irq, v, "irq");
    @(posedge pclk);
  endtask

  function automatic logic [15:0] op(input logic [3:0] f);
    return {`FMU_OPC_PREFIX, n, m, f};
  endfunction

  task automatic run(input logic [15:0] o,
                     input logic [31:0] fs, fd, gs, gd, ix);
    pc = $urandom();
    pc[0] = 1'b0;
    saw_req = 0;
    slow <= 2'($urandom());
    issue_opcode <= o;
    issue_pc <= pc;
    fp_src_data <= fs;
    fp_dst_data <= fd;
    gp_src_data <= gs;
    gp_dst_data <= gd;
    index_data <= ix;
    issue_valid <= 1;
    @(negedge pclk);
    while (issue_ready !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    issue_valid <= 0;
    lat = 0;
    do begin
      @(negedge pclk);
      lat++;
    end while (wb_valid !== 1'b1 && lat < 30);
    chk(wb_valid, 1, "writeback");
    ret++;
    {c_fe, c_fi, c_fd, c_ge} = {fp_wr_en, fp_wr_idx, fp_wr_data, gp_wr_en};
    {c_gi, c_gd, c_ae, c_io} = {gp_wr_idx, gp_wr_data, addr_error, invalid_op};
    c_pc = pc_next;
    @(posedge pclk);
  endtask

  task automatic expect_wb(input logic fe, input logic [31:0] fd,
                           input logic ge, input logic [3:0] gi,
                           input logic [31:0] gd, input logic ae, io);
    chk(c_fe, fe, "fp write");
    if (fe) begin
      chk(c_fi, n, "fp index");
      chk(c_fd, fd, "fp data");
    end
    chk(c_ge, ge, "gp write");
    if (ge) begin
      chk(c_gi, gi, "gp index");
      chk(c_gd, gd, "gp data");
    end
    chk(c_ae, ae, "address error");
    chk(c_io, io, "invalid");
    chk(c_pc, pc + `FMU_PC_STEP, "next pc");
  endtask

  // ========================================================================
  // Reference multiply; denormals read as zero by exponent test alone
  function automatic logic [32:0] fp_multiply_ref(input logic [31:0] a, b);
    logic [47:0] p;
    logic [9:0] e;
    logic s, za, zb, ia, ib;
    s = a[31] ^ b[31];
    {za, zb} = {a[30:23] == 8'h00, b[30:23] == 8'h00};
    {ia, ib} = {a[30:23] == 8'hFF, b[30:23] == 8'hFF};
    if ((ia && a[22]) || (ib && b[22]))
      return {1'b1, `FMU_QNAN};
    if ((ia && a[22:0] != 0) || (ib && b[22:0] != 0))
      return {1'b0, `FMU_QNAN};
    if ((za && ib) || (ia && zb))
      return {1'b1, `FMU_QNAN};
    if (ia || ib)
      return {2'b00 | s, 8'hFF, 23'h0};
    if (za || zb)
      return {2'b00 | s, 31'h0};
    p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
    e = a[30:23] + b[30:23] - `FMU_EXP_BIAS + p[47];
    return p[47] ? {2'b00 | s, e[7:0], p[46:24]} :
                   {2'b00 | s, e[7:0], p[45:23]};
  endfunction

  function automatic logic [31:0] rnd_norm();
    return {1'($urandom()), 8'h70 + 8'($urandom() % 32), 23'($urandom())};
  endfunction

  // ========================================================================
  // Main sequence
  initial begin
    logic [31:0] a, v, x, q;
    logic [32:0] r;
    logic e;
    void'($urandom(32'hF0DD));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk(issue_ready, 1, "ready after reset");
    apb(0, `FMU_STATUS_OFF, 0, q, e);
    chk(q, `FMU_STATUS_RST, "status reset");
    apb(0, `FMU_CTRL_OFF, 0, q, e);
    chk(q, `FMU_ENABLE_RST, "ctrl reset");
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      {n, m} = 8'($urandom());
      a = {8'h00, 1'b1, 21'($urandom()), 2'b00};
      v = $urandom();
      x = {24'h0, 6'($urandom()), 2'b00};
      run(op(`FMU_OPC_STORE), v, 0, 0, a, 0);
      expect_wb(0, 0, 0, 0, 0, 0, 0);
      chk(u_mem.mem[a[7:2]], v, "stored word");
      run(op(`FMU_OPC_LOAD), 0, 0, a, 0, 0);
      expect_wb(1, v, 0, 0, 0, 0, 0);
      run(op(`FMU_OPC_STORE_DEC), ~v, 0, 0, a + `FMU_ADDR_STEP, 0);
      expect_wb(0, 0, 1, n, a, 0, 0);
      run(op(`FMU_OPC_LOAD_INC), 0, 0, a, 0, 0);
      expect_wb(1, ~v, 1, m, a + `FMU_ADDR_STEP, 0, 0);
      run(op(`FMU_OPC_STORE_IDX), v ^ x, 0, 0, a - x, x);
      expect_wb(0, 0, 0, 0, 0, 0, 0);
      run(op(`FMU_OPC_LOAD_IDX), 0, 0, a - x, 0, x);
      expect_wb(1, v ^ x, 0, 0, 0, 0, 0);
      run(op(`FMU_OPC_MOVE), v, x, 0, 0, 0);
      expect_wb(1, v, 0, 0, 0, 0, 0);
      chk(saw_req, 0, "move used memory");
    end
    $display("test moves done");
    run(op(`FMU_OPC_LOAD_INC), 0, 0, a | 1, 0, 0);
    expect_wb(0, 0, 0, 0, 0, 1, 0);
    chk(saw_req, 0, "misaligned access issued");
    run(op(`FMU_OPC_STORE_DEC), v, 0, 0, 32'h80000010, 0);
    expect_wb(0, 0, 0, 0, 0, 1, 0);
    run(op(`FMU_OPC_LOAD_IDX), 0, 0, 32'h80000000, 0, 32'h00000040);
    expect_wb(0, 0, 0, 0, 0, 1, 0);
    $display("test faults done");
    for (int i = 0; i < 16; i++) begin
      {n, m} = 8'($urandom());
      {a, v} = (i < 8) ? mcase[i] : {rnd_norm(), rnd_norm()};
      r = fp_multiply_ref(a, v);
      run(op(`FMU_OPC_MUL), v, a, 0, 0, 0);
      expect_wb(1, r[31:0], 0, 0, 0, 0, r[32]);
      chk(c_io, r[32], "multiply invalid");
      chk(lat, `FMU_LATENCY, "multiply latency");
    end
    $display("test multiply done");
    issue_opcode <= {`FMU_OPC_PREFIX, n, m, 4'h5};
    issue_valid <= 1;
    @(posedge pclk);
    issue_valid <= 0;
    repeat (4) begin
      @(negedge pclk);
      chk(wb_valid, 0, "dropped op");
    end
    @(posedge pclk);
    $display("test decode done");
    apb(0, `FMU_STATUS_OFF, 0, q, e);
    chk(q[1:0], 2'h3, "status events");
    irq_is(0);
    apb(1, `FMU_MASK_OFF, 1, q, e);
    irq_is(1);
    apb(1, `FMU_STATUS_OFF, 1, q, e);
    irq_is(0);
    apb(0, `FMU_STATUS_OFF, 0, q, e);
    chk(q[1:0], 2'h2, "status after clear");
    apb(1, `FMU_MASK_OFF, 3, q, e);
    irq_is(1);
    apb(1, `FMU_STATUS_OFF, 2, q, e);
    irq_is(0);
    apb(0, 12'h010, 0, q, e);
    chk({q, e}, 33'h1, "unmapped read");
    apb(1, `FMU_RETIRED_OFF, 0, q, e);
    apb(0, `FMU_RETIRED_OFF, 0, q, e);
    chk(q, ret, "retired count");
    apb(1, `FMU_CTRL_OFF, 0, q, e);
    @(negedge pclk);
    chk(issue_ready, 0, "ready while disabled");
    @(posedge pclk);
    apb(1, `FMU_CTRL_OFF, 1, q, e);
    $display("test registers done");
    complete_run();
  end
endmodule // tb
